//--- bench/sfc_array_model.sv
// ****
// Array model
// ****
module sfc_array_model (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire sfc_pkg::sfc_arr_rd_t i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_erase_req,
  input wire logic [11:0] i_page,
  output logic o_erase_done,
  output logic o_wr_ready,
  input wire logic i_wr_valid,
  input wire sfc_pkg::sfc_arr_wr_t i_wr,
  input wire logic [9:0] i_probe,
  output logic [7:0] o_probe,
  output int o_n_wr,
  output logic [11:0] o_pg
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem_q [0:1023];
  logic [4:0] ecnt_q;
  logic [1:0] stall_q;
  assign o_wr_ready = stall_q != 2'h0;
  assign o_probe = mem_q[i_probe];
  // Data only valid the cycle after a request
  always_ff @(posedge i_clk) begin
    if (i_rd.req) begin
      o_rdata <= i_rd.page[7:0] ^ i_rd.offs[7:0] ^
        {6'h0, i_rd.offs[9:8]};
    end else begin
      o_rdata <= ~o_rdata;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ecnt_q <= 5'h0;
      stall_q <= 2'h0;
      o_erase_done <= 1'b0;
      o_n_wr <= 0;
      o_pg <= 12'h0;
    end else begin
      stall_q <= stall_q + 2'h1;
      ecnt_q <= i_erase_req ? ecnt_q + 5'h1 : 5'h0;
      o_erase_done <= i_erase_req && ecnt_q == 5'h13;
      if (i_erase_req) begin
        o_pg <= i_page;
        o_n_wr <= 0;
      end
      if (i_wr_valid && o_wr_ready) begin
        mem_q[i_wr.offs] <= i_wr.data;
        o_n_wr <= o_n_wr + 1;
      end
    end
  end
endmodule

//--- bench/sfc_cmd_asserts.sv
// ****
// Command interpreter checks
// ****
module sfc_cmd_asserts #(
  parameter int P_EP_CYCLES = 3500
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_cs_n,
  input wire logic i_arr_fail,
  input wire logic i_arr_wr_ready,
  input wire logic o_so_oe,
  input wire logic o_arr_erase_req,
  input wire logic o_arr_wr_valid,
  input wire sfc_pkg::sfc_arr_wr_t o_arr_wr,
  input wire logic o_device_busy_flag,
  input wire logic o_erase_program_error_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int EP_MAX = P_EP_CYCLES + 8;
  logic [31:0] busy_cnt_q;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !o_device_busy_flag) begin
      busy_cnt_q <= 32'h0;
    end else begin
      busy_cnt_q <= busy_cnt_q + 32'h1;
    end
  end
  chk_cs_float: assert property (
    $rose(i_cs_n) |-> ##[1:8] !o_so_oe)
    else $error("SO still driven after deselect");
  chk_cs_idle: assert property (
    i_cs_n [*8] |-> !o_so_oe)
    else $error("SO driven while deselected");
  chk_erase_first: assert property (
    $rose(o_device_busy_flag) |-> o_arr_erase_req)
    else $error("Busy began without erase");
  chk_write_busy: assert property (
    o_arr_wr_valid |-> o_device_busy_flag)
    else $error("Array write without busy");
  chk_busy_bound: assert property (
    busy_cnt_q <= EP_MAX)
    else $error("Busy too long");
  chk_err_set: assert property (
    o_device_busy_flag && i_arr_fail |=> o_erase_program_error_flag)
    else $error("Failure not flagged");
  chk_err_cause: assert property (
    $rose(o_erase_program_error_flag) |-> $past(o_device_busy_flag))
    else $error("Error flag outside busy");
  chk_write_hold: assert property (
    o_arr_wr_valid && !i_arr_wr_ready |=>
      o_arr_wr_valid && $stable(o_arr_wr))
    else $error("Write word lost on stall");
endmodule

bind sfc_cmd sfc_cmd_asserts #(.P_EP_CYCLES(P_EP_CYCLES)) chk_u (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cs_n(i_cs_n),
  .i_arr_fail(i_arr_fail), .i_arr_wr_ready(i_arr_wr_ready),
  .o_so_oe(o_so_oe), .o_arr_erase_req(o_arr_erase_req),
  .o_arr_wr_valid(o_arr_wr_valid), .o_arr_wr(o_arr_wr),
  .o_device_busy_flag(o_device_busy_flag),
  .o_erase_program_error_flag(o_erase_program_error_flag)
);

//--- bench/tb_top.sv
// ****
// Testbench
// ****
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, cs_n = 1, sck = 0, si = 0, bin = 0, fail = 0;
  logic so, oe, ereq, edone, wv, wrdy, busy, err;
  logic so_pin;
  logic [7:0] rdata, pv;
  logic [9:0] probe = 10'h0;
  logic [11:0] page, pg;
  sfc_pkg::sfc_arr_rd_t rd;
  sfc_pkg::sfc_arr_wr_t wr;
  int nwr;
  int n_fail = 0;
  int n_tests = 0;
  always #5 clk = ~clk;
  // Pull-up on the released data line
  assign so_pin = oe ? so : 1'b1;
  sfc_cmd #(.P_EP_CYCLES(3000)) dut_u (
    .i_clk(clk), .i_sys_rst(rst), .i_cs_n(cs_n), .i_sck(sck), .i_si(si),
    .o_so(so), .o_so_oe(oe), .i_binary_mode(bin), .o_arr_rd(rd),
    .i_arr_rdata(rdata), .o_arr_erase_req(ereq), .o_arr_page(page),
    .i_arr_erase_done(edone), .o_arr_wr_valid(wv), .i_arr_wr_ready(wrdy),
    .o_arr_wr(wr), .i_arr_fail(fail), .o_device_busy_flag(busy),
    .o_erase_program_error_flag(err));
  sfc_array_model part_u (
    .i_clk(clk), .i_sys_rst(rst), .i_rd(rd), .o_rdata(rdata),
    .i_erase_req(ereq), .i_page(page), .o_erase_done(edone),
    .o_wr_ready(wrdy), .i_wr_valid(wv), .i_wr(wr), .i_probe(probe),
    .o_probe(pv), .o_n_wr(nwr), .o_pg(pg));
  function automatic logic [7:0] ad(logic [11:0] p, logic [9:0] o);
    return p[7:0] ^ o[7:0] ^ {6'h0, o[9:8]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic half();
    repeat (4) @(posedge clk);
    #1;
  endtask
  // One byte each way, MSB first, SO read late in the high phase
  task automatic xb(input logic [7:0] o, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      sck = 0;
      si = o[i];
      half();
      sck = 1;
      half();
      r[i] = so_pin;
    end
  endtask
  task automatic start(input logic [7:0] op, input logic [23:0] a,
                       input int nd);
    logic [7:0] t;
    cs_n = 0;
    half();
    xb(op, t);
    xb(a[23:16], t);
    xb(a[15:8], t);
    xb(a[7:0], t);
    repeat (nd) xb(8'h00, t);
  endtask
  task automatic stop();
    sck = 0;
    half();
    cs_n = 1;
    repeat (8) @(posedge clk);
    #1;
    chk(oe, 0);
  endtask
  task automatic t_arr(input logic [7:0] op, input logic m,
                       input logic [11:0] p, input logic [9:0] o,
                       input int nd, input logic [11:0] np);
    logic [7:0] r;
    bin = m;
    start(op, m ? {3'h0, p, o[8:0]} : {2'h0, p, o}, nd);
    xb(8'hff, r);
    chk(r, ad(p, o));
    xb(8'hff, r);
    chk(r, ad(np, 10'h0));
    chk(oe, 1);
    stop();
    bin = 0;
  endtask
  // Unknown opcode: line must stay released
  task automatic t_ign();
    logic [7:0] r;
    start(8'h55, 24'h000000, 0);
    xb(8'hff, r);
    chk(oe, 0);
    chk(r, 8'hff);
    stop();
  endtask
  task automatic t_buf(input logic w, input logic [7:0] op, input int nd,
                       input logic m, input logic [9:0] o,
                       input logic [7:0] b);
    logic [7:0] r;
    bin = m;
    start(op, {14'h0, o}, nd);
    for (int i = 0; i < 2; i++) begin
      xb(b + 8'(i), r);
      if (!w) chk(r, b + 8'(i));
    end
    stop();
    bin = 0;
  endtask
  task automatic t_pgm(input logic [7:0] op, input logic m,
                       input logic [11:0] p, input logic f, input int n,
                       input logic [9:0] o, input logic [7:0] b);
    bin = m;
    start(op, m ? {3'h0, p, 9'h0} : {2'h0, p, 10'h0}, 0);
    stop();
    chk(busy, 1);
    fail = f;
    @(posedge clk);
    #1;
    fail = 0;
    for (int i = 0; i < 4000 && busy === 1'b1; i++) @(posedge clk);
    #1;
    probe = o;
    #1;
    chk(busy, 0);
    chk(err, f);
    chk(nwr, n);
    chk(pg, p);
    chk(pv, b);
    bin = 0;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    #1;
    rst = 0;
    repeat (4) @(posedge clk);
    #1;
    t_buf(1, 8'h84, 0, 0, 10'h20f, 8'h10);
    t_buf(1, 8'h87, 0, 1, 10'h1ff, 8'h20);
    t_arr(8'h01, 0, 12'h005, 10'h20f, 0, 12'h006);
    t_arr(8'h01, 0, 12'hfff, 10'h20f, 0, 12'h000);
    t_arr(8'h01, 1, 12'h009, 10'h1ff, 0, 12'h00a);
    t_arr(8'hd2, 0, 12'h007, 10'h20f, 4, 12'h007);
    t_arr(8'hd2, 1, 12'h007, 10'h1ff, 4, 12'h007);
    t_ign();
    t_buf(0, 8'hd4, 1, 0, 10'h20f, 8'h10);
    t_buf(0, 8'hd1, 0, 0, 10'h20f, 8'h10);
    t_buf(0, 8'hd6, 1, 1, 10'h1ff, 8'h20);
    t_buf(0, 8'hd3, 0, 1, 10'h1ff, 8'h20);
    t_pgm(8'h83, 0, 12'h009, 1, 528, 10'h20f, 8'h10);
    t_pgm(8'h86, 1, 12'h003, 0, 512, 10'h1ff, 8'h20);
    results();
  end
  initial begin
    #900000;
    n_fail++;
    results();
  end
endmodule

//--- design/sfc_cmd.sv
`include "sfc_regs.svh"

// ************************************************************
// Program data FIFO
// ************************************************************
module sfc_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_clear,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;
  logic full;
  logic empty;
  logic push;
  logic pop;

  assign empty = (wp_q == rp_q);
  assign full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  assign o_in_ready = !full;
  assign o_out_valid = !empty;
  assign o_out_data = mem_q[rp_q[AW-1:0]];
  assign push = i_in_valid && !full;
  assign pop = i_out_ready && !empty;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || i_clear) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wp_q[AW-1:0]] <= i_in_data;
    end
  end
endmodule

// ************************************************************
// Command interpreter
// ************************************************************
module sfc_cmd #(
  parameter int P_EP_CYCLES = `SFC_EP_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_si,
  output logic o_so,
  output logic o_so_oe,
  input wire logic i_binary_mode,
  output sfc_pkg::sfc_arr_rd_t o_arr_rd,
  input wire logic [7:0] i_arr_rdata,
  output logic o_arr_erase_req,
  output logic [11:0] o_arr_page,
  input wire logic i_arr_erase_done,
  output logic o_arr_wr_valid,
  input wire logic i_arr_wr_ready,
  output sfc_pkg::sfc_arr_wr_t o_arr_wr,
  input wire logic i_arr_fail,
  output logic o_device_busy_flag,
  output logic o_erase_program_error_flag
);
  sfc_pkg::sfc_regs_t q;
  sfc_pkg::sfc_regs_t d;
  logic [7:0] buf_mem_q [2][`SFC_BUF_WORDS];
  logic [7:0] buf_rdata_q;
  logic mem_we;
  logic [9:0] mem_raddr;
  logic fifo_push;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_clear;
  sfc_pkg::sfc_arr_wr_t fifo_in;

  // ************************************************************
  // Sequencer
  // ************************************************************
  always_comb begin
    logic cs_n;
    logic cs_fall;
    logic sck_rise;
    logic sck_fall;
    logic si;
    logic byte_done;
    logic [7:0] byte_v;
    logic [23:0] a;
    logic [9:0] last;
    logic in_frame;
    cs_n = q.cs_sync[1];
    cs_fall = !q.cs_sync[1] && q.cs_sync[2];
    sck_rise = q.sck_sync[1] && !q.sck_sync[2];
    sck_fall = !q.sck_sync[1] && q.sck_sync[2];
    si = q.si_sync[1];
    byte_done = sck_rise && (q.bit_cnt == `SFC_BIT_LAST);
    byte_v = {q.sr[6:0], si};
    a = {q.addr[15:0], byte_v};
    last = i_binary_mode ? `SFC_BIN_LAST : `SFC_STD_LAST;
    in_frame = (q.st != sfc_pkg::ST_IDLE) && (q.st != sfc_pkg::ST_ERASE) &&
      (q.st != sfc_pkg::ST_PROG);
    d = q;
    d.cs_sync = {q.cs_sync[1:0], i_cs_n};
    d.sck_sync = {q.sck_sync[1:0], i_sck};
    d.si_sync = {q.si_sync[0], i_si};
    d.rd_req = 1'b0;
    d.rd_ld = q.rd_req;
    mem_we = 1'b0;
    fifo_push = 1'b0;
    fifo_in = '{offs: q.pgm_idx, data: buf_rdata_q};
    if (sck_rise) begin
      d.sr = byte_v;
      d.bit_cnt = q.bit_cnt + 3'h1;
    end
    if (q.rd_ld && q.st == sfc_pkg::ST_RDATA) begin
      if (q.cmd == sfc_pkg::CMD_LP_READ || q.cmd == sfc_pkg::CMD_PAGE_READ)
      begin
        d.nxt = i_arr_rdata;
      end else begin
        d.nxt = buf_rdata_q;
      end
      if (q.offs >= last) begin
        d.offs = '0;
        if (q.cmd == sfc_pkg::CMD_LP_READ) begin
          d.page = q.page + 12'h001;
        end
      end else begin
        d.offs = q.offs + 10'h001;
      end
    end
    case (q.st)
      sfc_pkg::ST_IDLE: begin
        if (cs_fall) begin
          d.st = sfc_pkg::ST_OPC;
          d.bit_cnt = '0;
        end
      end
      sfc_pkg::ST_OPC: begin
        if (byte_done) begin
          d.cnt = '0;
          d.st = sfc_pkg::ST_ADDR;
          d.bsel = (byte_v == `SFC_OP_B2_RD_FAST) ||
            (byte_v == `SFC_OP_B2_RD_SLOW) || (byte_v == `SFC_OP_B2_WRITE) ||
            (byte_v == `SFC_OP_B2_PGM);
          if (byte_v == `SFC_OP_LP_READ) begin
            d.cmd = sfc_pkg::CMD_LP_READ;
          end else if (byte_v == `SFC_OP_PAGE_READ) begin
            d.cmd = sfc_pkg::CMD_PAGE_READ;
          end else if (byte_v == `SFC_OP_B1_RD_FAST ||
              byte_v == `SFC_OP_B2_RD_FAST) begin
            d.cmd = sfc_pkg::CMD_BUF_FAST;
          end else if (byte_v == `SFC_OP_B1_RD_SLOW ||
              byte_v == `SFC_OP_B2_RD_SLOW) begin
            d.cmd = sfc_pkg::CMD_BUF_SLOW;
          end else if (byte_v == `SFC_OP_B1_WRITE ||
              byte_v == `SFC_OP_B2_WRITE) begin
            d.cmd = sfc_pkg::CMD_BUF_WRITE;
          end else if (byte_v == `SFC_OP_B1_PGM ||
              byte_v == `SFC_OP_B2_PGM) begin
            d.cmd = sfc_pkg::CMD_PGM;
          end else begin
            d.st = sfc_pkg::ST_IGNORE;
          end
        end
      end
      sfc_pkg::ST_ADDR: begin
        if (byte_done) begin
          d.addr = a;
          d.cnt = q.cnt + 3'h1;
          if (q.cnt == `SFC_ADDR_LAST) begin
            d.cnt = '0;
            if (i_binary_mode) begin
              d.page = 12'(a >> `SFC_BIN_PAGE_LSB);
              d.offs = {1'b0, a[8:0]};
            end else begin
              d.page = 12'(a >> `SFC_STD_PAGE_LSB);
              d.offs = a[9:0];
            end
            if (q.cmd == sfc_pkg::CMD_PAGE_READ ||
                q.cmd == sfc_pkg::CMD_BUF_FAST) begin
              d.st = sfc_pkg::ST_DUMMY;
            end else if (q.cmd == sfc_pkg::CMD_BUF_WRITE) begin
              d.st = sfc_pkg::ST_WDATA;
            end else if (q.cmd == sfc_pkg::CMD_PGM) begin
              d.st = sfc_pkg::ST_PGM_WAIT;
            end else begin
              d.st = sfc_pkg::ST_RDATA;
              d.rd_req = 1'b1;
              d.so_oe = 1'b1;
              d.bit_cnt = '0;
            end
          end
        end
      end
      sfc_pkg::ST_DUMMY: begin
        if (byte_done) begin
          d.cnt = q.cnt + 3'h1;
          if (q.cmd == sfc_pkg::CMD_BUF_FAST ||
              q.cnt == `SFC_PAGE_DUMMY_LAST) begin
            d.st = sfc_pkg::ST_RDATA;
            d.rd_req = 1'b1;
            d.so_oe = 1'b1;
            d.bit_cnt = '0;
          end
        end
      end
      sfc_pkg::ST_RDATA: begin
        d.bit_cnt = q.bit_cnt;
        d.sr = q.sr;
        if (sck_fall) begin
          d.bit_cnt = q.bit_cnt + 3'h1;
          if (q.bit_cnt == '0) begin
            d.so_sr = q.nxt;
            d.rd_req = 1'b1;
          end else begin
            d.so_sr = {q.so_sr[6:0], 1'b0};
          end
        end
      end
      sfc_pkg::ST_WDATA: begin
        if (byte_done) begin
          mem_we = 1'b1;
          d.offs = (q.offs >= last) ? '0 : q.offs + 10'h001;
        end
      end
      sfc_pkg::ST_ERASE: begin
        d.ep_cnt = q.ep_cnt + 32'h1;
        if (i_arr_erase_done) begin
          d.st = sfc_pkg::ST_PROG;
          d.pgm_idx = '0;
          d.pgm_all = 1'b0;
          d.pgm_pend = 1'b0;
        end
      end
      sfc_pkg::ST_PROG: begin
        d.ep_cnt = q.ep_cnt + 32'h1;
        if (!q.pgm_all && !q.pgm_pend && fifo_in_ready) begin
          d.rd_req = 1'b1;
          d.pgm_pend = 1'b1;
        end
        if (q.rd_ld) begin
          fifo_push = 1'b1;
          d.pgm_pend = 1'b0;
          if (q.pgm_idx >= last) begin
            d.pgm_all = 1'b1;
          end else begin
            d.pgm_idx = q.pgm_idx + 10'h001;
          end
        end
        if (q.pgm_all && !fifo_out_valid) begin
          d.st = sfc_pkg::ST_IDLE;
        end
      end
      default: begin
      end
    endcase
    if (in_frame && cs_n) begin
      d.so_oe = 1'b0;
      d.so_sr = '0;
      d.st = sfc_pkg::ST_IDLE;
      if (q.st == sfc_pkg::ST_PGM_WAIT) begin
        d.st = sfc_pkg::ST_ERASE;
        d.ep_cnt = '0;
        d.err = 1'b0;
      end
    end
    if ((q.st == sfc_pkg::ST_ERASE || q.st == sfc_pkg::ST_PROG) &&
        q.ep_cnt >= 32'(P_EP_CYCLES - 1)) begin
      d.st = sfc_pkg::ST_IDLE;
      d.err = 1'b1;
    end
    if ((q.st == sfc_pkg::ST_ERASE || q.st == sfc_pkg::ST_PROG) &&
        i_arr_fail) begin
      d.err = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      q <= '0;
      q.cs_sync <= 3'h7;
      q.sck_sync <= '0;
      q.st <= sfc_pkg::ST_IDLE;
      q.cmd <= sfc_pkg::CMD_LP_READ;
    end else begin
      q <= d;
    end
  end

  // ************************************************************
  // Buffers
  // ************************************************************
  assign mem_raddr = (q.st == sfc_pkg::ST_PROG) ? q.pgm_idx : q.offs;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_buf
      always_ff @(posedge i_clk) begin
        if (mem_we && q.bsel == 1'(g)) begin
          buf_mem_q[g][q.offs] <= {q.sr[6:0], q.si_sync[1]};
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    if (q.rd_req) begin
      buf_rdata_q <= buf_mem_q[q.bsel][mem_raddr];
    end
  end

  assign fifo_clear = (q.st != sfc_pkg::ST_PROG);

  sfc_fifo #(
    .WIDTH($bits(sfc_pkg::sfc_arr_wr_t)),
    .DEPTH(`SFC_FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_clear(fifo_clear),
    .i_in_valid(fifo_push),
    .o_in_ready(fifo_in_ready),
    .i_in_data(fifo_in),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(i_arr_wr_ready),
    .o_out_data(o_arr_wr)
  );

  // ************************************************************
  // Outputs
  // ************************************************************
  assign o_so = q.so_sr[7];
  assign o_so_oe = q.so_oe;

  // ************************************************************
  // Array read, erase and write ports, status flags
  // ************************************************************
  always_comb begin
    o_arr_rd = '0;
    o_arr_rd.page = q.page;
    o_arr_rd.offs = q.offs;
    if (q.st == sfc_pkg::ST_RDATA && q.rd_req) begin
      if (q.cmd == sfc_pkg::CMD_LP_READ ||
          q.cmd == sfc_pkg::CMD_PAGE_READ) begin
        o_arr_rd.req = 1'b1;
      end
    end
  end

  assign o_arr_erase_req = (q.st == sfc_pkg::ST_ERASE);
  assign o_arr_page = q.page;
  assign o_arr_wr_valid = fifo_out_valid;
  assign o_device_busy_flag = (q.st == sfc_pkg::ST_ERASE) ||
    (q.st == sfc_pkg::ST_PROG);
  assign o_erase_program_error_flag = q.err;
endmodule

//--- design/sfc_pkg.sv
package sfc_pkg;

  typedef enum logic [3:0] {
    ST_IDLE, ST_OPC, ST_ADDR, ST_DUMMY, ST_RDATA, ST_WDATA,
    ST_PGM_WAIT, ST_IGNORE, ST_ERASE, ST_PROG
  } sfc_state_t;

  typedef enum logic [2:0] {
    CMD_LP_READ, CMD_PAGE_READ, CMD_BUF_FAST, CMD_BUF_SLOW,
    CMD_BUF_WRITE, CMD_PGM
  } sfc_cmd_t;

  typedef struct packed {
    logic req;
    logic [11:0] page;
    logic [9:0] offs;
  } sfc_arr_rd_t;

  typedef struct packed {
    logic [9:0] offs;
    logic [7:0] data;
  } sfc_arr_wr_t;

  typedef struct packed {
    logic [2:0] cs_sync;
    logic [2:0] sck_sync;
    logic [1:0] si_sync;
    sfc_state_t st;
    sfc_cmd_t cmd;
    logic bsel;
    logic [2:0] bit_cnt;
    logic [7:0] sr;
    logic [2:0] cnt;
    logic [23:0] addr;
    logic [11:0] page;
    logic [9:0] offs;
    logic rd_req;
    logic rd_ld;
    logic [7:0] nxt;
    logic [7:0] so_sr;
    logic so_oe;
    logic err;
    logic [31:0] ep_cnt;
    logic [9:0] pgm_idx;
    logic pgm_pend;
    logic pgm_all;
  } sfc_regs_t;

endpackage

//--- design/sfc_regs.svh
// How it works
// - Opcode 01h plus three address bytes, no dummies, then array data out.
// - Standard mode: 12 page bits over a 10-bit byte offset.
// - Binary mode: A20..A9 pick the page, A8..A0 the byte.
// - Continuous read runs on into the next page without a stall.
// - After the last array byte the read wraps to page zero at once.
// - Chip select rising ends any read and floats serial output.
// - Array reads never touch either buffer.
// - Opcode D2h, three address bytes, four dummy bytes, then data.
// - Page read wraps to the start of the same page.
// - D4h/D1h read buffer one, D6h/D3h read buffer two.
// - Buffer read address: dummy bits then a 10 or 9 bit offset.
// - D4h and D6h need one dummy byte; D1h and D3h none.
// - Buffer read wraps to the start of the same buffer.
// - 84h/87h write buffer one/two from a 10-bit offset.
// - Binary mode buffer write takes a 9-bit start offset.
// - Write bytes land at rising offsets, wrapping, until chip select rises.
// - 83h/86h program from buffer one/two; page in bits 21..10.
// - Binary mode program takes the page from bits 20..9.
// - On chip select rising, erase the page then program the buffer.
// - Busy flag stands while erase and program run.
// - Any erase or program failure sets the error flag.
`ifndef SFC_REGS_SVH
`define SFC_REGS_SVH

// ************************************************************
// Opcodes
// ************************************************************
`define SFC_OP_LP_READ 8'h01
`define SFC_OP_PAGE_READ 8'hd2
`define SFC_OP_B1_RD_FAST 8'hd4
`define SFC_OP_B1_RD_SLOW 8'hd1
`define SFC_OP_B2_RD_FAST 8'hd6
`define SFC_OP_B2_RD_SLOW 8'hd3
`define SFC_OP_B1_WRITE 8'h84
`define SFC_OP_B2_WRITE 8'h87
`define SFC_OP_B1_PGM 8'h83
`define SFC_OP_B2_PGM 8'h86

// ************************************************************
// Frame layout
// ************************************************************
`define SFC_BIT_LAST 3'h7
`define SFC_ADDR_LAST 3'h2
`define SFC_PAGE_DUMMY_LAST 3'h3
`define SFC_STD_PAGE_LSB 10
`define SFC_BIN_PAGE_LSB 9
`define SFC_STD_LAST 10'h20f
`define SFC_BIN_LAST 10'h1ff
`define SFC_BUF_WORDS 528
`define SFC_FIFO_DEPTH 8

// ************************************************************
// Timing
// ************************************************************
`define SFC_CLK_NS 10
`define SFC_EP_TIME_US 35
`define SFC_EP_CYCLES ((`SFC_EP_TIME_US * 1000) / `SFC_CLK_NS)

`endif
